/* core/recip_counter.sv */
`timescale 1ns/100ps

// How it works
// - While the gate is open the event count rises on each input cycle (on the stop pulse in interval mode) and the time count on every clock.
// - Single period opens the gate for one input cycle and reports clock count times clock period.
// - Period averaging keeps the gate open for several cycles and reports period times clocks over events.
// - Frequency averaging reports the reciprocal of the average period as a frequency.
// - With external arming only an input cycle after the arming edge may start the measurement, except a fixed time gate run, which opens on the edge.
// - With automatic arming the first input cycle of a burst starts the measurement unaided; a fixed time gate run opens at the start command.
// - In interval mode a start pulse opens the gate, a stop pulse closes it, clocks between are the time.
// - Resolution is one period of the counted clock, and the gate logic runs on that same clock.
// - Each channel picks the rising or the falling crossing for its trigger pulse.
// - A common setting feeds the stop channel from the start channel's input.
// - Each channel sends a pulse to the gate when its input crosses the set level.
// - In smart frequency mode a too fast input switches the next run to a fixed time gate count.
module recip_counter
	import recip_pkg::*;
#(
	parameter logic [CNT_W-1:0] CONV_GATE_RST = CONV_GATE_DEF
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire logic i_sig_a,
	input wire logic i_sig_b,
	input wire logic i_arm,
	output logic o_gate,
	output logic o_trig_start,
	output logic o_trig_stop,
	output logic o_busy,
	output logic o_done,
	output logic [RES_W-1:0] o_result
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WAIT_ARM = 5'h02,
		ST_WAIT_OPEN = 5'h04,
		ST_GATE = 5'h08,
		ST_CALC = 5'h10
	} state_type;

	state_type state_reg;
	state_type state_next;
	ctrl_type ctrl_reg;
	ctrl_type run_reg;
	logic run_conv_reg;
	logic conv_reg;
	logic [CNT_W-1:0] cycles_reg;
	logic [CNT_W-1:0] conv_gate_reg;
	logic [CNT_W-1:0] event_reg;
	logic [CNT_W-1:0] time_reg;
	logic [RES_W-1:0] result_reg;
	logic done_reg;
	logic done_pulse_reg;
	logic gate_reg;
	logic calc_go_reg;
	logic sig_a_reg;
	logic sig_b_reg;
	logic arm_prev_reg;
	trig_type trig_out_reg;
	logic [DATA_W-1:0] rdata_reg;

	logic start_cmd;
	logic abort_cmd;
	logic arm_edge;
	logic rise_a;
	logic fall_a;
	logic stop_src;
	logic rise_b;
	logic fall_b;
	trig_type trig;
	logic in_gate;
	logic close_gate;
	logic ev_inc;
	logic [CNT_W-1:0] ev_plus;
	logic [CNT_W-1:0] time_plus;
	logic [CNT_W-1:0] cycles_eff;
	logic [CNT_W-1:0] conv_eff;
	logic conv_now;
	ctrl_type ctrl_wr;
	logic [RES_W-1:0] div_num;
	logic [CNT_W-1:0] div_den;
	logic div_busy;
	logic div_done;
	logic [RES_W-1:0] div_quot;
	logic [STAT_W-1:0] status;
	logic fast_input;

	// ****************************************
	// Register writes
	// ****************************************
	// Start is refused while a measurement runs, so run_reg keeps its mode and arming; slopes, common and gate lengths follow later writes
	assign start_cmd = i_wr && (i_addr == ADDR_CTRL) && i_wdata[CTRL_START]
		&& (state_reg == ST_IDLE);
	assign abort_cmd = i_wr && (i_addr == ADDR_CTRL) && i_wdata[CTRL_ABORT];
	// Settings written together with the start bit govern that run
	assign ctrl_wr = ctrl_type'(i_wdata[CTRL_W-1:0]);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_reg <= ctrl_type'(CTRL_RST);
			cycles_reg <= CYCLES_RST;
			conv_gate_reg <= CONV_GATE_RST;
		end else if (i_wr) begin
			if (i_addr == ADDR_CTRL) begin
				ctrl_reg <= ctrl_type'(i_wdata[CTRL_W-1:0]);
			end
			if (i_addr == ADDR_CYCLES) begin
				cycles_reg <= i_wdata;
			end
			if (i_addr == ADDR_CONV_GATE) begin
				conv_gate_reg <= i_wdata;
			end
		end
	end

	// ****************************************
	// Trigger channels
	// ****************************************
	// Inputs are already comparator outputs, synchronous to the clock
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sig_a_reg <= 1'b0;
			sig_b_reg <= 1'b0;
			arm_prev_reg <= 1'b0;
		end else begin
			sig_a_reg <= i_sig_a;
			sig_b_reg <= stop_src;
			arm_prev_reg <= i_arm;
		end
	end

	assign stop_src = ctrl_reg.common ? i_sig_a : i_sig_b;
	assign rise_a = i_sig_a && !sig_a_reg;
	assign fall_a = !i_sig_a && sig_a_reg;
	assign rise_b = stop_src && !sig_b_reg;
	assign fall_b = !stop_src && sig_b_reg;
	assign trig.start = ctrl_reg.slope_a ? fall_a : rise_a;
	assign trig.stop = ctrl_reg.slope_b ? fall_b : rise_b;
	assign arm_edge = i_arm && !arm_prev_reg;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			trig_out_reg <= '0;
		end else begin
			trig_out_reg <= trig;
		end
	end

	// ****************************************
	// Gate control
	// ****************************************
	assign in_gate = (state_reg == ST_GATE);
	assign ev_plus = event_reg + CNT_ONE;
	assign time_plus = time_reg + CNT_ONE;
	assign cycles_eff = (cycles_reg == '0) ? CNT_ONE : cycles_reg;
	assign conv_eff = (conv_gate_reg == '0) ? CNT_ONE : conv_gate_reg;
	assign conv_now = conv_reg && ctrl_wr.smart && (ctrl_wr.mode == MODE_FREQ_AVG);

	always_comb begin
		close_gate = 1'b0;
		ev_inc = 1'b0;
		if (in_gate) begin
			if (run_conv_reg) begin
				ev_inc = trig.start;
				close_gate = (time_plus >= conv_eff);
			end else if (run_reg.mode == MODE_INTERVAL) begin
				ev_inc = trig.stop;
				close_gate = trig.stop;
			end else if (run_reg.mode == MODE_PERIOD) begin
				ev_inc = trig.start;
				close_gate = trig.start;
			end else begin
				ev_inc = trig.start;
				close_gate = trig.start && (ev_plus >= cycles_eff);
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_cmd) begin
					if (ctrl_wr.arm_ext) begin
						state_next = ST_WAIT_ARM;
					end else if (conv_now) begin
						state_next = ST_GATE;
					end else begin
						state_next = ST_WAIT_OPEN;
					end
				end
			end
			ST_WAIT_ARM: begin
				// A trigger in the arming cycle itself is not taken
				if (arm_edge) begin
					state_next = run_conv_reg ? ST_GATE : ST_WAIT_OPEN;
				end
			end
			ST_WAIT_OPEN: begin
				if (trig.start) begin
					state_next = ST_GATE;
				end
			end
			ST_GATE: begin
				if (close_gate) begin
					state_next = ST_CALC;
				end
			end
			ST_CALC: begin
				if (div_done) begin
					state_next = ST_IDLE;
				end
			end
		endcase
		if (abort_cmd) begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= ST_IDLE;
			gate_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			gate_reg <= (state_next == ST_GATE);
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			run_reg <= ctrl_type'(CTRL_RST);
			run_conv_reg <= 1'b0;
		end else if (start_cmd) begin
			run_reg <= ctrl_wr;
			run_conv_reg <= conv_now;
		end
	end

	// ****************************************
	// Event and time counters
	// ****************************************
	// Time counts on the system clock, so one count is one clock period
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			event_reg <= '0;
			time_reg <= '0;
		end else if (start_cmd) begin
			event_reg <= '0;
			time_reg <= '0;
		end else if (in_gate) begin
			time_reg <= time_plus;
			if (ev_inc) begin
				event_reg <= ev_plus;
			end
		end
	end

	// ****************************************
	// Arithmetic
	// ****************************************
	// Periods come out in picoseconds, frequencies in hertz
	always_comb begin
		div_num = RES_W'(time_reg) * PS_PER_CLK;
		div_den = event_reg;
		unique case (run_reg.mode)
			MODE_PERIOD: begin
				div_num = RES_W'(time_reg) * PS_PER_CLK;
				div_den = event_reg;
			end
			MODE_PER_AVG: begin
				div_num = RES_W'(time_reg) * PS_PER_CLK;
				div_den = event_reg;
			end
			MODE_FREQ_AVG: begin
				div_num = RES_W'(event_reg) * CLK_HZ;
				div_den = time_reg;
			end
			MODE_INTERVAL: begin
				div_num = RES_W'(time_reg) * PS_PER_CLK;
				div_den = CNT_ONE;
			end
		endcase
	end

	// Divider starts a cycle after closing so it sees the final counts
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			calc_go_reg <= 1'b0;
		end else begin
			calc_go_reg <= in_gate && close_gate && !abort_cmd;
		end
	end

	div_unit u_div (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_start(calc_go_reg),
		.i_num(div_num),
		.i_den(div_den),
		.o_busy(div_busy),
		.o_done(div_done),
		.o_quot(div_quot)
	);

	// Fast means at least one input cycle every two clocks
	assign fast_input = ({event_reg, 1'b0} >= {1'b0, time_reg});

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			result_reg <= '0;
			done_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
			conv_reg <= 1'b0;
		end else begin
			done_pulse_reg <= 1'b0;
			if (start_cmd) begin
				done_reg <= 1'b0;
			end
			if ((state_reg == ST_CALC) && div_done && !abort_cmd) begin
				result_reg <= div_quot;
				done_reg <= 1'b1;
				done_pulse_reg <= 1'b1;
				if (run_reg.smart && (run_reg.mode == MODE_FREQ_AVG)) begin
					conv_reg <= fast_input;
				end
			end
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	always_comb begin
		status = '0;
		status[STAT_BUSY] = (state_reg != ST_IDLE) || div_busy;
		status[STAT_DONE] = done_reg;
		status[STAT_GATE] = gate_reg;
		status[STAT_CONV] = conv_reg;
		status[STAT_ARMED] = (state_reg == ST_WAIT_OPEN);
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_reg <= '0;
		end else if (i_rd) begin
			unique case (i_addr)
				ADDR_CTRL: rdata_reg <= DATA_W'(ctrl_reg);
				ADDR_CYCLES: rdata_reg <= cycles_reg;
				ADDR_STATUS: rdata_reg <= DATA_W'(status);
				ADDR_EVENTS: rdata_reg <= event_reg;
				ADDR_TIME: rdata_reg <= time_reg;
				ADDR_RES_LO: rdata_reg <= result_reg[DATA_W-1:0];
				ADDR_RES_HI: rdata_reg <= result_reg[RES_W-1:DATA_W];
				ADDR_CONV_GATE: rdata_reg <= conv_gate_reg;
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_rdata = rdata_reg;
	assign o_gate = gate_reg;
	assign o_trig_start = trig_out_reg.start;
	assign o_trig_stop = trig_out_reg.stop;
	assign o_busy = status[STAT_BUSY];
	assign o_done = done_pulse_reg;
	assign o_result = result_reg;

endmodule

/* shared/recip_pkg.sv */
package recip_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 32;
	localparam int RES_W = 64;
	localparam int CTRL_W = 7;
	localparam int STEP_W = 7;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CYCLES = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_EVENTS = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_TIME = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_RES_LO = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_RES_HI = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_CONV_GATE = 8'h1C;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_START = 8;
	localparam int CTRL_ABORT = 9;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_GATE = 2;
	localparam int STAT_CONV = 3;
	localparam int STAT_ARMED = 4;
	localparam int STAT_W = 5;

	// ****************************************
	// Modes and carriers
	// ****************************************
	typedef enum logic [1:0] {
		MODE_PERIOD = 2'h0,
		MODE_PER_AVG = 2'h1,
		MODE_FREQ_AVG = 2'h2,
		MODE_INTERVAL = 2'h3
	} mode_type;

	typedef struct packed {
		logic smart;
		logic common;
		logic slope_b;
		logic slope_a;
		logic arm_ext;
		mode_type mode;
	} ctrl_type;

	typedef struct packed {
		logic start;
		logic stop;
	} trig_type;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [CNT_W-1:0] CYCLES_RST = 32'h0000_0001;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
	localparam int CLK_PERIOD_NS = 5;
	localparam int PS_PER_NS = 1000;
	localparam int NS_PER_S = 1000000000;
	localparam logic [RES_W-1:0] PS_PER_CLK = RES_W'(CLK_PERIOD_NS * PS_PER_NS);
	localparam logic [RES_W-1:0] CLK_HZ = RES_W'(NS_PER_S / CLK_PERIOD_NS);
	localparam int CONV_GATE_US = 1000;
	localparam logic [CNT_W-1:0] CONV_GATE_DEF = CNT_W'(CONV_GATE_US * 1000 / CLK_PERIOD_NS);
	localparam logic [STEP_W-1:0] DIV_STEPS = STEP_W'(RES_W);

endpackage

/* core/div_unit.sv */
`timescale 1ns/100ps

module div_unit
	import recip_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic [RES_W-1:0] i_num,
	input wire logic [CNT_W-1:0] i_den,
	output logic o_busy,
	output logic o_done,
	output logic [RES_W-1:0] o_quot
);

	// ****************************************
	// Restoring division, one bit per clock
	// ****************************************
	// A zero divisor yields all ones rather than a trap
	logic [CNT_W:0] rem_reg;
	logic [RES_W-1:0] quot_reg;
	logic [CNT_W-1:0] den_reg;
	logic [STEP_W-1:0] step_reg;
	logic busy_reg;
	logic done_reg;
	logic [CNT_W:0] trial;
	logic fits;

	assign trial = {rem_reg[CNT_W-1:0], quot_reg[RES_W-1]};
	assign fits = trial >= {1'b0, den_reg};

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rem_reg <= '0;
			quot_reg <= '0;
			den_reg <= '0;
			step_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (i_start && !busy_reg) begin
				rem_reg <= '0;
				quot_reg <= i_num;
				den_reg <= i_den;
				step_reg <= DIV_STEPS;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				rem_reg <= fits ? (trial - {1'b0, den_reg}) : trial;
				quot_reg <= {quot_reg[RES_W-2:0], fits};
				step_reg <= step_reg - 7'h01;
				if (step_reg == 7'h01) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_quot = quot_reg;

endmodule

/* dv/recip_counter_props.sv */
`timescale 1ns/100ps

module recip_counter_props
	import recip_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_sig_a,
	input wire logic i_sig_b,
	input wire logic i_arm,
	input wire logic o_gate,
	input wire logic o_trig_start,
	input wire logic o_trig_stop,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic [RES_W-1:0] o_result
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_done_pulse;
		o_done ##1 !o_done;
	endsequence

	sequence s_stop_edge;
		$past(i_sig_a) != $past(i_sig_a, 2) || $past(i_sig_b) != $past(i_sig_b, 2);
	endsequence

	// Trigger pulses run free, so only the gate may depend on arming; a fast-input
	// run may open it straight from idle or on an arm edge with no start pulse
	sequence s_open_cause;
		o_trig_start || !$past(o_busy) || ($past(i_arm) && !$past(i_arm, 2));
	endsequence

	// Fixed latency lets software poll without a timeout
	AST_DONE_LATENCY: assert property (o_done |-> $past(o_gate, 67) && !$past(o_gate, 66))
		else $error("done not 67 cycles after gate close");
	AST_DONE_SINGLE: assert property (o_done |-> s_done_pulse)
		else $error("done longer than one cycle");
	AST_RESULT_HOLD: assert property ($changed(o_result) |-> o_done)
		else $error("result moved without done");
	AST_GATE_BUSY: assert property (o_gate |-> o_busy)
		else $error("gate open while idle");
	AST_TRIG_START_EDGE: assert property (o_trig_start |-> $past(i_sig_a) != $past(i_sig_a, 2))
		else $error("start pulse without input edge");
	AST_TRIG_STOP_EDGE: assert property (o_trig_stop |-> s_stop_edge)
		else $error("stop pulse without input edge");
	AST_GATE_OPEN_CAUSE: assert property ($rose(o_gate) |-> s_open_cause)
		else $error("gate opened without start pulse");
	AST_TRIG_SHORT: assert property (o_trig_start |=> !o_trig_start)
		else $error("start pulse longer than one cycle");
endmodule

bind recip_counter recip_counter_props u_props (.i_clk, .i_nrst, .i_sig_a, .i_sig_b, .i_arm,
	.o_gate, .o_trig_start, .o_trig_stop, .o_busy, .o_done, .o_result);

/* dv/sig_source.sv */
`timescale 1ns/100ps

module sig_source (
	input wire logic i_clk,
	output logic o_sig_a,
	output logic o_sig_b,
	output logic o_arm
);
	// ****************************************
	// Conditioned inputs
	// ****************************************
	// Lines idle low so the first driven level is a clean rising crossing
	initial begin
		o_sig_a = 1'b0;
		o_sig_b = 1'b0;
		o_arm = 1'b0;
	end

	task automatic drive(input logic a, input logic b, input int gap);
		repeat (gap) @(posedge i_clk);
		o_sig_a <= a;
		o_sig_b <= b;
	endtask

	task automatic square(input int per, input int rises);
		repeat (rises) begin
			drive(1'b1, o_sig_b, per / 2);
			drive(1'b0, o_sig_b, per - per / 2);
		end
	endtask

	task automatic pulse_arm();
		@(posedge i_clk);
		o_arm <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_arm <= 1'b0;
	endtask
endmodule

/* dv/recip_counter_tb.sv */
`timescale 1ns/100ps

module recip_counter_tb
	import recip_pkg::*;
;
	logic i_clk, i_nrst, i_wr, i_rd, i_sig_a, i_sig_b, i_arm, gate_seen;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata, rd_val;
	logic o_gate, o_trig_start, o_trig_stop, o_busy, o_done;
	logic [RES_W-1:0] o_result;
	int err_total;
	int num_checks;

	recip_counter #(.CONV_GATE_RST(CNT_W'(20))) u_dut (.i_clk, .i_nrst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_sig_a, .i_sig_b, .i_arm, .o_gate, .o_trig_start,
		.o_trig_stop, .o_busy, .o_done, .o_result);
	sig_source u_src (.i_clk, .o_sig_a(i_sig_a), .o_sig_b(i_sig_b), .o_arm(i_arm));

	// ****************************************
	// Clock and helpers
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (o_gate === 1'b1) begin
			gate_seen <= 1'b1;
		end
	end

	task automatic chk(input string name, input logic [RES_W-1:0] exp,
		input logic [RES_W-1:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic bus_rd(input logic [ADDR_W-1:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		rd_val = o_rdata;
	endtask

	task automatic start_run(input logic [6:0] c, input logic [DATA_W-1:0] n);
		bus_wr(ADDR_CYCLES, n);
		bus_wr(ADDR_CTRL, DATA_W'(c) | (DATA_W'(1) << CTRL_START));
	endtask

	task automatic finish_run(input int ev, input int tm, input logic [RES_W-1:0] res);
		int i;
		for (i = 0; i < 300 && o_done !== 1'b1; i++) begin
			@(posedge i_clk);
			#1;
		end
		if (o_done !== 1'b1) begin
			err_total++;
			print_verdict();
		end
		chk("result", res, o_result);
		bus_rd(ADDR_EVENTS);
		chk("events", RES_W'(ev), RES_W'(rd_val));
		bus_rd(ADDR_TIME);
		chk("time", RES_W'(tm), RES_W'(rd_val));
		bus_rd(ADDR_RES_LO);
		chk("result low", RES_W'(res[31:0]), RES_W'(rd_val));
		bus_rd(ADDR_RES_HI);
		chk("result high", RES_W'(res[63:32]), RES_W'(rd_val));
	endtask

	task automatic run(input logic [6:0] c, input int n, input int per, input int rises,
		input int ev, input int tm, input logic [RES_W-1:0] res);
		start_run(c, DATA_W'(n));
		u_src.square(per, rises);
		finish_run(ev, tm, res);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_nrst = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		gate_seen = 1'b0;
		err_total = 0;
		num_checks = 0;
		repeat (10) @(posedge i_clk);
		i_nrst <= 1'b1;
		bus_rd(ADDR_CYCLES);
		chk("cycles reset", RES_W'(CYCLES_RST), RES_W'(rd_val));
		bus_rd(ADDR_CONV_GATE);
		chk("conv gate reset", RES_W'(20), RES_W'(rd_val));
		bus_rd(8'h40);
		chk("unmapped", '0, RES_W'(rd_val));
		run(7'h00, 1, 5, 3, 1, 5, 5 * PS_PER_CLK);
		run(7'h08, 1, 6, 3, 1, 6, 6 * PS_PER_CLK);
		run(7'h01, 3, 4, 4, 3, 12, 12 * PS_PER_CLK / 3);
		run(7'h01, 0, 8, 2, 1, 8, 8 * PS_PER_CLK);
		run(7'h02, 4, 6, 5, 4, 24, 4 * CLK_HZ / 24);
		start_run(7'h03, 1);
		u_src.drive(1'b1, 1'b0, 3);
		u_src.drive(1'b1, 1'b1, 7);
		u_src.drive(1'b0, 1'b0, 2);
		finish_run(1, 7, 7 * PS_PER_CLK);
		// Stop line toggles inside the gate as a decoy; common mode must ignore it
		start_run(7'h33, 1);
		u_src.drive(1'b1, 1'b0, 3);
		u_src.drive(1'b1, 1'b1, 2);
		u_src.drive(1'b0, 1'b0, 4);
		finish_run(1, 6, 6 * PS_PER_CLK);
		start_run(7'h04, 1);
		gate_seen <= 1'b0;
		u_src.square(4, 2);
		chk("gate before arm", '0, RES_W'(gate_seen));
		u_src.pulse_arm();
		u_src.square(5, 3);
		finish_run(1, 5, 5 * PS_PER_CLK);
		// Abort inside an open gate must keep the previous result and leave an idle status
		gate_seen <= 1'b0;
		start_run(7'h00, 1);
		u_src.drive(1'b1, 1'b0, 3);
		bus_wr(ADDR_CTRL, DATA_W'(1) << CTRL_ABORT);
		bus_rd(ADDR_STATUS);
		chk("status after abort", '0, RES_W'(rd_val));
		chk("gate before abort", RES_W'(1), RES_W'(gate_seen));
		chk("result after abort", 5 * PS_PER_CLK, o_result);
		u_src.drive(1'b0, 1'b0, 1);
		// A two-clock input period is fast, so the next smart run uses a 20-clock gate
		run(7'h42, 4, 2, 5, 4, 8, 4 * CLK_HZ / 8);
		bus_rd(ADDR_STATUS);
		chk("status conv", RES_W'((1 << STAT_DONE) | (1 << STAT_CONV)), RES_W'(rd_val));
		run(7'h42, 4, 2, 10, 10, 20, 10 * CLK_HZ / 20);
		print_verdict();
	end
endmodule
